// [src/ceb_core.sv]
// ceb_core: exception entry, priority and banked register file
// assumes requests from core sources; irq and fast lines are asynchronous
`timescale 1ns/100ps
module ceb_core
   import ceb_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // asynchronous interrupt lines
   input wire logic irq_req,
   input wire logic fast_interrupt_request,
   // synchronous exception events from the pipeline
   input wire logic abort_req,
   input wire logic undef_req,
   input wire logic software_interrupt_instruction,
   input wire logic load_multiple_busy,
   input wire logic [31:0] return_pc,
   input wire logic exc_return,
   // register file access
   input wire ceb_regwr_t reg_wr,
   input wire logic [3:0] reg_rd_idx,
   input wire logic compressed_set,
   // multiply unit
   input wire logic mul_go,
   input wire logic mul_acc,
   input wire logic [31:0] mul_a,
   input wire logic [31:0] mul_b,
   // test port access to debug registers
   input wire ceb_dbgreg_t dbg_port,
   input wire logic [31:0] fetch_addr,
   input wire logic [31:0] data_addr,
   input wire logic dbg_resume,
   // outputs
   output logic [31:0] reg_rd_data,
   output logic [31:0] fetch_pc,
   output logic fetch_valid,
   output logic wide_set,
   output ceb_mode_t mode,
   output logic [31:0] current_program_status,
   output logic [63:0] mul_result,
   output logic [31:0] dbg_rd_data,
   output logic debug_halt
);
   typedef enum {ST_RUN, ST_ENTRY, ST_DEBUG} ceb_st_t;

   // ==================================================================
   // synchronise the asynchronous requests
   logic [1:0] sync_req;
   ceb_sync #(.WIDTH(2)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({fast_interrupt_request, irq_req}),
      .sync_out(sync_req)
   );
   logic irq_s;
   logic fast_s;
   assign irq_s = sync_req[0];
   assign fast_s = sync_req[1];

   // ==================================================================
   // registers: user r0-r14, fast r8-r14, sp/lr for four other modes
   logic [31:0] usr_reg [0:14];
   logic [31:0] fast_reg [CEB_FAST_LO:CEB_REG_LR];
   logic [31:0] bank_sp [0:3];
   logic [31:0] bank_lr [0:3];
   logic [31:0] saved_status [0:4];
   logic [31:0] bkpt;
   logic [31:0] wpt;
   logic [1:0] bw_en;
   ceb_st_t st;
   ceb_st_t next_st;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   ceb_mode_t next_mode;
   logic [31:0] next_pc;
   logic next_wide;
   logic next_fetch_valid;
   logic next_halt;
   ceb_mode_t tgt;
   logic [31:0] tgt_vec;
   logic take;

   // bank index for the four non-fast exception modes
   function automatic logic [1:0] bidx(input ceb_mode_t m);
      case (m)
         CEB_MODE_IRQ: bidx = 2'h0;
         CEB_MODE_ABORT: bidx = 2'h1;
         CEB_MODE_UNDEF: bidx = 2'h2;
         default: bidx = 2'h3;
      endcase
   endfunction

   // priority: abort, fast, irq, undefined, software; fast ahead of irq
   always_comb begin
      take = 1'b1;
      tgt = CEB_MODE_USER;
      tgt_vec = CEB_VEC_FAST;
      if (abort_req) begin
         tgt = CEB_MODE_ABORT;
         tgt_vec = CEB_VEC_ABT;
      end else if (fast_s && mode != CEB_MODE_FAST) begin
         tgt = CEB_MODE_FAST;
         tgt_vec = CEB_VEC_FAST;
      end else if (irq_s && mode == CEB_MODE_USER) begin
         tgt = CEB_MODE_IRQ;
         tgt_vec = CEB_VEC_IRQ;
      end else if (undef_req) begin
         tgt = CEB_MODE_UNDEF;
         tgt_vec = CEB_VEC_UND;
      end else if (software_interrupt_instruction) begin
         tgt = CEB_MODE_SOFT;
         tgt_vec = CEB_VEC_SOFT;
      end else begin
         take = 1'b0;
      end
   end

   // ==================================================================
   // sequencer: run, exception entry, debug halt
   logic bw_hit;
   assign bw_hit = (bw_en[0] && fetch_addr == bkpt)
      || (bw_en[1] && data_addr == wpt);
   logic entering;
   assign entering = st == ST_RUN && take && !load_multiple_busy && !bw_hit;

   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_mode = mode;
      next_pc = fetch_pc;
      next_wide = wide_set;
      next_fetch_valid = fetch_valid;
      next_halt = debug_halt;
      unique case (st)
         ST_RUN: begin
            // long load-multiple finishes first: worst latency
            if (bw_hit) begin
               next_st = ST_DEBUG;
               next_halt = 1'b1;
               next_fetch_valid = 1'b0;
            end else if (entering) begin
               next_st = ST_ENTRY;
               next_cnt = '0;
               next_mode = tgt;
               next_pc = tgt_vec;
               next_wide = 1'b1;
               next_fetch_valid = 1'b0;
            end else if (exc_return && mode != CEB_MODE_USER) begin
               next_mode = CEB_MODE_USER;
               next_pc = return_pc;
               next_wide = ~compressed_set;
            end else if (mode == CEB_MODE_USER) begin
               next_wide = ~compressed_set;
            end else begin
               next_wide = 1'b1;
            end
         end
         ST_ENTRY: begin
            // entry cycles complete the five-cycle minimum
            if (cnt == CEB_ENTRY_LAST) begin
               next_st = ST_RUN;
               next_fetch_valid = 1'b1; // vector fetch
            end else begin
               next_cnt = 3'(cnt + 3'h1);
            end
         end
         ST_DEBUG: begin
            if (dbg_resume) begin
               next_st = ST_RUN;
               next_halt = 1'b0;
               next_fetch_valid = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= ST_RUN;
         cnt <= '0;
         mode <= CEB_MODE_USER;
         fetch_pc <= CEB_PC_RST;
         wide_set <= 1'b1;
         fetch_valid <= 1'b1;
         debug_halt <= 1'b0;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         mode <= next_mode;
         fetch_pc <= next_pc;
         wide_set <= next_wide;
         fetch_valid <= next_fetch_valid;
         debug_halt <= next_halt;
      end
   end

   // ==================================================================
   // banked register writes; entry loads the link copy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 5; i++) begin
            saved_status[i] <= '0;
         end
      end else if (entering) begin
         if (tgt == CEB_MODE_FAST) begin
            fast_reg[CEB_REG_LR] <= return_pc;
            saved_status[4] <= current_program_status;
         end else begin
            bank_lr[bidx(tgt)] <= return_pc;
            saved_status[bidx(tgt)] <= current_program_status;
         end
      end else if (reg_wr.wr && reg_wr.idx != 4'(CEB_REG_PC)) begin
         if (mode == CEB_MODE_FAST && reg_wr.idx >= 4'(CEB_FAST_LO))
            fast_reg[reg_wr.idx] <= reg_wr.data;
         else if (mode != CEB_MODE_USER && mode != CEB_MODE_FAST
                  && reg_wr.idx == 4'(CEB_REG_SP))
            bank_sp[bidx(mode)] <= reg_wr.data;
         else if (mode != CEB_MODE_USER && mode != CEB_MODE_FAST
                  && reg_wr.idx == 4'(CEB_REG_LR))
            bank_lr[bidx(mode)] <= reg_wr.data;
         else
            usr_reg[reg_wr.idx] <= reg_wr.data;
      end
   end

   // read port: r15 returns pc, banked copies chosen by mode
   logic [31:0] next_rd;
   always_comb begin
      if (reg_rd_idx == 4'(CEB_REG_PC))
         next_rd = fetch_pc;
      else if (mode == CEB_MODE_FAST && reg_rd_idx >= 4'(CEB_FAST_LO))
         next_rd = fast_reg[reg_rd_idx];
      else if (mode != CEB_MODE_USER && reg_rd_idx == 4'(CEB_REG_SP))
         next_rd = bank_sp[bidx(mode)];
      else if (mode != CEB_MODE_USER && reg_rd_idx == 4'(CEB_REG_LR))
         next_rd = bank_lr[bidx(mode)];
      else
         next_rd = usr_reg[reg_rd_idx];
   end

   // status word: mode code and instruction-set flag
   logic [31:0] next_status;
   always_comb begin
      next_status = {26'h0, ~next_wide, 2'h0, 3'(next_mode)};
   end

   // ==================================================================
   // long multiply, 32 x 32 to 64 with optional accumulate
   logic [63:0] next_mul;
   always_comb begin
      next_mul = mul_result;
      if (mul_go)
         next_mul = {32'h0, mul_a} * {32'h0, mul_b}
            + (mul_acc ? mul_result : 64'h0);
   end

   // ==================================================================
   // debug registers reached only from the test port
   logic [31:0] next_dbg;
   always_comb begin
      next_dbg = dbg_rd_data;
      if (dbg_port.re)
         next_dbg = dbg_port.sel[0] ? wpt : bkpt;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rd_data <= '0;
         current_program_status <= '0;
         mul_result <= '0;
         dbg_rd_data <= '0;
         bkpt <= '0;
         wpt <= '0;
         bw_en <= '0;
      end else begin
         reg_rd_data <= next_rd;
         current_program_status <= next_status;
         mul_result <= next_mul;
         dbg_rd_data <= next_dbg;
         if (dbg_port.we && dbg_port.sel == 2'h0) bkpt <= dbg_port.data;
         if (dbg_port.we && dbg_port.sel == 2'h1) wpt <= dbg_port.data;
         if (dbg_port.we && dbg_port.sel == 2'h2) bw_en <= dbg_port.data[1:0];
      end
   end
   // bus widths are upheld by the 32-bit ports of this block

   // ==================================================================
   // checks
   sequence fast_enter_s;
      st == ST_RUN && entering && tgt == CEB_MODE_FAST;
   endsequence

   fast_vector_a: assert property (@(posedge clk) disable iff (!rst_n)
      fast_enter_s |=> mode == CEB_MODE_FAST && fetch_pc == CEB_VEC_FAST
      ##2 fetch_valid)
      else $error("fast entry did not fetch the fast vector");
   fast_first_a: assert property (@(posedge clk) disable iff (!rst_n)
      entering && fast_s && irq_s && mode == CEB_MODE_USER && !abort_req
      |=> mode == CEB_MODE_FAST)
      else $error("irq taken ahead of fast interrupt");
   wide_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
      entering |=> wide_set)
      else $error("exception entered in compressed set");
   priv_wide_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode != CEB_MODE_USER |-> wide_set)
      else $error("privileged mode running compressed set");
   min_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
      entering |-> ##1 !fetch_valid [*2] ##1 fetch_valid)
      else $error("entry length wrong");
   halt_on_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
      st == ST_RUN && bw_hit |=> debug_halt && !fetch_valid)
      else $error("break or watch hit did not halt");
   long_load_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
      load_multiple_busy && !exc_return |=> $stable(mode))
      else $error("exception entered during load multiple");
   mul_value_a: assert property (@(posedge clk) disable iff (!rst_n)
      mul_go && !mul_acc |=> mul_result
      == {32'h0, $past(mul_a)} * {32'h0, $past(mul_b)})
      else $error("long multiply result wrong");
   fast_bank_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode == CEB_MODE_FAST && reg_wr.wr && reg_wr.idx == 4'h8
      |=> $stable(usr_reg[8]))
      else $error("fast-mode write disturbed user r8");
   abort_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
      entering && abort_req |=> mode == CEB_MODE_ABORT)
      else $error("abort did not enter abort mode");
endmodule

// [src/ceb_pkg.sv]
// ceb_pkg: shared constants and types for the exception and banking unit
// assumes one core clock at 20 MHz and a synchronous active-low reset
package ceb_pkg;
   // ==================================================================
   // processor modes
   typedef enum logic [2:0] {
      CEB_MODE_USER,
      CEB_MODE_IRQ,
      CEB_MODE_FAST,
      CEB_MODE_ABORT,
      CEB_MODE_UNDEF,
      CEB_MODE_SOFT
   } ceb_mode_t;

   // ==================================================================
   // exception kinds, one-hot request vector order
   localparam int CEB_EXC_KINDS = 5;
   localparam int CEB_EXC_IRQ = 0;
   localparam int CEB_EXC_FAST = 1;
   localparam int CEB_EXC_ABT = 2;
   localparam int CEB_EXC_UND = 3;
   localparam int CEB_EXC_SOFT = 4;

   // ==================================================================
   // register file shape
   localparam int CEB_NUM_GPR = 31;
   localparam int CEB_NUM_PSR = 6;
   localparam int CEB_REG_PC = 15;
   localparam int CEB_REG_SP = 13;
   localparam int CEB_REG_LR = 14;
   localparam int CEB_FAST_LO = 8;
   localparam int CEB_FAST_HI = 12;

   // ==================================================================
   // vectors and reset values
   localparam logic [31:0] CEB_VEC_UND = 32'h0000_0004;
   localparam logic [31:0] CEB_VEC_SOFT = 32'h0000_0008;
   localparam logic [31:0] CEB_VEC_ABT = 32'h0000_0010;
   localparam logic [31:0] CEB_VEC_IRQ = 32'h0000_0018;
   localparam logic [31:0] CEB_VEC_FAST = 32'h0000_001C;
   localparam logic [31:0] CEB_PC_RST = 32'h0000_0000;

   // ==================================================================
   // timing: entry takes the cycles left after a 2-flop synchroniser and the take cycle
   localparam int CEB_MIN_LATENCY = 5;
   localparam int CEB_SYNC_STAGES = 2;
   localparam int CEB_ENTRY_CYCLES = CEB_MIN_LATENCY - CEB_SYNC_STAGES - 1;
   localparam logic [2:0] CEB_ENTRY_LAST = 3'(CEB_ENTRY_CYCLES - 1);

   // ==================================================================
   // grouped carriers
   typedef struct packed {
      logic       wr;
      logic [3:0] idx;
      logic [31:0] data;
   } ceb_regwr_t;

   typedef struct packed {
      logic       we;
      logic       re;
      logic [1:0] sel;
      logic [31:0] data;
   } ceb_dbgreg_t;
endpackage

// [src/ceb_sync.sv]
// ceb_sync: two-flop synchroniser for asynchronous request levels
// assumes the inputs are levels held long enough for the core clock
`timescale 1ns/100ps
module ceb_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync_out;

   // the first stage feeds only the second stage
   always_comb begin
      next_meta = async_in;
      next_sync_out = meta;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= next_meta;
         sync_out <= next_sync_out;
      end
   end
endmodule

// [bench/ceb_partner.sv]
// ceb_partner: interrupt sources and test-port host facing ceb_core
// assumes its tasks are called just after a rising edge of clk
`timescale 1ns/100ps
module ceb_partner
   import ceb_pkg::*;
(
   // clock
   input wire logic clk,
   // request lines
   output logic irq_req,
   output logic fast_interrupt_request,
   // test port
   output ceb_dbgreg_t dbg_port
);
   // ===================================================================
   // idle levels: no request, no port strobe
   initial begin
      irq_req = 1'b0;
      fast_interrupt_request = 1'b0;
      dbg_port = '0;
   end

   // request levels are held until the sources are told to drop them
   task automatic set_lines(input logic irq, input logic fast);
      irq_req <= irq;
      fast_interrupt_request <= fast;
   endtask

   // one port access, strobe held for one edge; the released data
   // shows the inverse so a stale sample cannot pass for a good one
   task automatic port_access(input logic we, input logic [1:0] sel,
                              input logic [31:0] data);
      @(posedge clk);
      dbg_port <= '{we: we, re: ~we, sel: sel, data: data};
      @(posedge clk);
      dbg_port <= '{we: 1'b0, re: 1'b0, sel: sel, data: ~data};
   endtask
endmodule

// [bench/test_cpu_exception_banking.sv]
// test_cpu_exception_banking: self-checking bench for ceb_core
// assumes ceb_partner supplies the interrupt lines and the test port
`timescale 1ns/100ps
module test_cpu_exception_banking
   import ceb_pkg::*;
;
   logic clk, rst_n, irq_req, fast_interrupt_request, abort_req, undef_req;
   logic software_interrupt_instruction, load_multiple_busy, exc_return;
   logic compressed_set, mul_go, mul_acc, dbg_resume;
   logic fetch_valid, wide_set, debug_halt;
   logic [31:0] return_pc, mul_a, mul_b, fetch_addr, data_addr, reg_rd_data;
   logic [31:0] fetch_pc, current_program_status, dbg_rd_data, rpc, bp;
   logic [3:0] reg_rd_idx;
   logic [63:0] mul_result, m_acc;
   ceb_regwr_t reg_wr;
   ceb_dbgreg_t dbg_port;
   ceb_mode_t mode;
   int err_total, check_count;
   logic [31:0] m_usr [15];
   logic [31:0] m_fast [8:13];
   ceb_mode_t k_mode [5] = '{CEB_MODE_IRQ, CEB_MODE_FAST, CEB_MODE_ABORT,
                             CEB_MODE_UNDEF, CEB_MODE_SOFT};
   logic [31:0] k_vec [5] = '{CEB_VEC_IRQ, CEB_VEC_FAST, CEB_VEC_ABT,
                              CEB_VEC_UND, CEB_VEC_SOFT};

   // ===================================================================
   // clock and instances
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ceb_core i_dut (.clk, .rst_n, .irq_req, .fast_interrupt_request,
      .abort_req, .undef_req, .software_interrupt_instruction,
      .load_multiple_busy, .return_pc, .exc_return, .reg_wr, .reg_rd_idx,
      .compressed_set, .mul_go, .mul_acc, .mul_a, .mul_b, .dbg_port,
      .fetch_addr, .data_addr, .dbg_resume, .reg_rd_data, .fetch_pc,
      .fetch_valid, .wide_set, .mode, .current_program_status, .mul_result,
      .dbg_rd_data, .debug_halt);
   ceb_partner i_partner (.clk, .irq_req, .fast_interrupt_request,
      .dbg_port);

   // ===================================================================
   // compare and closing tasks
   task automatic chk_word(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_long(input string what, input logic [63:0] exp,
                           input logic [63:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ===================================================================
   // drivers; a hung wait counts as a mismatch and closes the run
   task automatic wait_mode(input ceb_mode_t m);
      int n;
      n = 0;
      while (mode !== m && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_word("mode", 32'(m), 32'(mode));
      if (mode !== m) test_done();
   endtask
   task automatic set_req(input logic [4:0] v);
      @(posedge clk);
      i_partner.set_lines(v[CEB_EXC_IRQ], v[CEB_EXC_FAST]);
      abort_req <= v[CEB_EXC_ABT];
      undef_req <= v[CEB_EXC_UND];
      software_interrupt_instruction <= v[CEB_EXC_SOFT];
   endtask
   task automatic wr_reg(input logic [3:0] idx, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= '{wr: 1'b1, idx: idx, data: d};
      @(posedge clk);
      reg_wr <= '{wr: 1'b0, idx: idx, data: ~d};
   endtask
   task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
      @(posedge clk);
      reg_rd_idx <= idx;
      @(posedge clk);
      #1;
      chk_word("reg_rd_data", exp, reg_rd_data);
   endtask
   // waits for the synchronised request to clear before returning
   task automatic leave(input logic [31:0] pc);
      repeat (3) @(posedge clk);
      return_pc <= pc;
      exc_return <= 1'b1;
      @(posedge clk);
      exc_return <= 1'b0;
      #1;
      wait_mode(CEB_MODE_USER);
      chk_word("fetch_pc", pc, fetch_pc);
   endtask
   task automatic dbg_hit;
      int n;
      n = 0;
      while (debug_halt !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_word("debug_halt", 32'h1, 32'(debug_halt));
      chk_word("fetch_valid", 32'h0, 32'(fetch_valid));
      if (debug_halt !== 1'b1) test_done();
      @(posedge clk);
      fetch_addr <= 32'hFFFF_FFF0;
      data_addr <= 32'hFFFF_FFF0;
      dbg_resume <= 1'b1;
      @(posedge clk);
      dbg_resume <= 1'b0;
      #1;
      chk_word("resume", 32'h3, {30'h0, fetch_valid, ~debug_halt});
   endtask

   // ===================================================================
   // main sequence
   initial begin
      {rst_n, load_multiple_busy, exc_return, compressed_set} = '0;
      {mul_go, mul_acc, dbg_resume, abort_req, undef_req} = '0;
      software_interrupt_instruction = 1'b0;
      {return_pc, mul_a, mul_b, reg_rd_idx, reg_wr, m_acc} = '0;
      fetch_addr = 32'hFFFF_FFF0;
      data_addr = 32'hFFFF_FFF0;
      err_total = 0;
      check_count = 0;
      void'($urandom(4386));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk_word("reset", {CEB_PC_RST[28:0], 3'(CEB_MODE_USER)},
               {fetch_pc[28:0], 3'(mode)});
      chk_word("reset flags", 32'h6,
               32'({fetch_valid, wide_set, debug_halt}));
      // user view: r0..r14 write and read back
      for (int i = 0; i < 15; i++) begin
         m_usr[i] = $urandom();
         wr_reg(4'(i), m_usr[i]);
      end
      for (int i = 0; i < 15; i++) rd_chk(4'(i), m_usr[i]);
      // every kind from compressed code: mode, vector, set, link copy
      for (int k = 0; k < CEB_EXC_KINDS; k++) begin
         @(posedge clk);
         compressed_set <= 1'b1;
         rpc = $urandom() & 32'hFFFF_FFFC;
         return_pc <= rpc;
         @(posedge clk);
         #1;
         chk_word("wide_set user", 32'h0, 32'(wide_set));
         chk_word("status user", 32'h0000_0020,
                  current_program_status);
         set_req(5'(1 << k));
         #1;
         wait_mode(k_mode[k]);
         chk_word("vector", k_vec[k], fetch_pc);
         chk_word("wide_set exc", 32'h1, 32'(wide_set));
         chk_word("status", {29'h0, 3'(k_mode[k])},
                  current_program_status);
         set_req(5'h00);
         rd_chk(4'(CEB_REG_LR), rpc);
         rd_chk(4'h0, m_usr[0]);
         leave(rpc ^ 32'h0000_0100);
         rd_chk(4'(CEB_REG_LR), m_usr[CEB_REG_LR]);
      end
      compressed_set <= 1'b0;
      // fast request latency: 2 sync edges, take, 2 entry cycles
      @(posedge clk);
      i_partner.set_lines(1'b0, 1'b1);
      repeat (2) @(posedge clk);
      #1;
      chk_word("mode sync", 32'(CEB_MODE_USER), 32'(mode));
      @(posedge clk);
      #1;
      chk_word("mode fast", 32'(CEB_MODE_FAST), 32'(mode));
      chk_word("fast vector", CEB_VEC_FAST, fetch_pc);
      @(posedge clk);
      #1;
      chk_word("valid entry", 32'h0, 32'(fetch_valid));
      @(posedge clk);
      #1;
      chk_word("valid fetch", 32'h1, 32'(fetch_valid));
      // fast bank r8..r13 kept apart from the user copies
      set_req(5'h00);
      for (int i = CEB_FAST_LO; i <= CEB_REG_SP; i++) begin
         m_fast[i] = $urandom();
         wr_reg(4'(i), m_fast[i]);
      end
      rd_chk(4'h7, m_usr[7]);
      leave(32'h0000_0200);
      for (int i = CEB_FAST_LO; i <= CEB_REG_SP; i++) begin
         rd_chk(4'(i), m_usr[i]);
      end
      // both interrupts pending: fast first, normal after return
      set_req(5'h03);
      #1;
      wait_mode(CEB_MODE_FAST);
      rd_chk(4'(CEB_FAST_LO), m_fast[CEB_FAST_LO]);
      set_req(5'h01);
      leave(32'h0000_0300);
      wait_mode(CEB_MODE_IRQ);
      rd_chk(4'(CEB_FAST_LO), m_usr[CEB_FAST_LO]);
      set_req(5'h00);
      leave(32'h0000_0304);
      // sync order, and entry held off by a long load
      load_multiple_busy <= 1'b1;
      set_req(5'h1C);
      repeat (4) @(posedge clk);
      #1;
      chk_word("busy hold", 32'(CEB_MODE_USER), 32'(mode));
      @(posedge clk);
      load_multiple_busy <= 1'b0;
      #1;
      wait_mode(CEB_MODE_ABORT);
      set_req(5'h00);
      leave(32'h0000_0400);
      set_req(5'h18);
      #1;
      wait_mode(CEB_MODE_UNDEF);
      set_req(5'h00);
      leave(32'h0000_0404);
      // long multiply and accumulate with random operands
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         mul_a <= $urandom();
         mul_b <= $urandom();
         mul_acc <= 1'(i % 2);
         mul_go <= 1'b1;
         @(posedge clk);
         mul_go <= 1'b0;
         #1;
         m_acc = (i % 2 ? m_acc : 64'h0) + 64'(mul_a) * 64'(mul_b);
         chk_long("mul_result", m_acc, mul_result);
      end
      // break and watch registers through the test port, then hits
      bp = $urandom() & 32'h0000_FFFC;
      for (int s = 0; s < 2; s++) begin
         i_partner.port_access(1'b1, 2'(s), bp + 32'(s * 8));
         i_partner.port_access(1'b0, 2'(s), 32'h0);
         #1;
         chk_word("dbg_rd_data", bp + 32'(s * 8), dbg_rd_data);
      end
      i_partner.port_access(1'b1, 2'h2, 32'h0000_0003);
      @(posedge clk);
      fetch_addr <= bp;
      dbg_hit();
      @(posedge clk);
      data_addr <= bp + 32'h8;
      dbg_hit();
      test_done();
   end
endmodule
